// ===== design/lps_array_ctrl.sv
// Controller end: divides sys_clk into the link clock, issues start pulses,
// counts edges and hands each pixel sample out through a two-entry buffer.
// Assumes the array end on the same link interface; one clock, async reset.
`include "lps_regs.svh"

module lps_array_ctrl
(
  input  wire logic                    sys_clk,
  input  wire logic                    arst_n,
  lps_link_if.ctrl                     link,
  input  wire logic                    frameReq,
  output logic                         frameBusy,
  output logic                         linkFault,
  output logic                         pixValid,
  input  wire logic                    pixReady,
  output logic [`LPS_IDX_W-1:0]        pixIndex,
  output logic [`LPS_LEVEL_W-1:0]      pixLevel
);

  localparam logic [`LPS_TIMER_W-1:0] HALF_LOAD = `LPS_TIMER_W'(`LPS_HALF_CYC - 1);

  lps_pkg::lps_ctl_st_t st_r;
  lps_pkg::lps_ctl_st_t st_nxt;
  logic                 pop;
  logic                 push;
  logic                 canPush;
  logic                 sampleDue;
  lps_pkg::lps_sample_t sample;

  always_comb
  begin
    st_nxt    = st_r;
    pop       = (st_r.fifoCnt != 2'h0) && pixReady;
    canPush   = (st_r.fifoCnt != 2'h2) || pop;
    push      = 1'b0;
    // Pixel n is on the pin for the whole low phase after edge n
    sampleDue = (st_r.edges != '0) && (st_r.edges <= `LPS_LAST_PIXEL);
    sample.idx   = `LPS_IDX_W'(st_r.edges - `LPS_EDGE_W'(1));
    sample.level = link.pixelVoltageIn;

    case (st_r.state)
      lps_pkg::CTL_IDLE:
      begin
        st_nxt.pixClk = 1'b0;
        // Exposure is whatever gap the user leaves between requests
        if (frameReq)
        begin
          st_nxt.startPulse = 1'b1;
          st_nxt.edges      = '0;
          st_nxt.linkFault  = 1'b0;
          st_nxt.timer      = HALF_LOAD;
          st_nxt.state      = lps_pkg::CTL_LOW;
        end
      end
      lps_pkg::CTL_LOW:
      begin
        if (st_r.timer != '0)
          st_nxt.timer = st_r.timer - `LPS_TIMER_W'(1);
        else if (!(sampleDue && !canPush))
        begin
          // A full buffer holds the link clock low, so no sample is lost
          if (sampleDue)
          begin
            push = 1'b1;
            if (!link.pixelVoltageIn[0] && link.pixelVoltageIn == `LPS_LEVEL_RST)
              st_nxt.linkFault = st_r.linkFault;
          end
          st_nxt.pixClk = 1'b1;
          st_nxt.edges  = st_r.edges + `LPS_EDGE_W'(1);
          st_nxt.timer  = HALF_LOAD;
          st_nxt.state  = lps_pkg::CTL_HIGH;
        end
      end
      lps_pkg::CTL_HIGH:
      begin
        if (st_r.timer != '0)
          st_nxt.timer = st_r.timer - `LPS_TIMER_W'(1);
        else
        begin
          st_nxt.pixClk     = 1'b0;
          st_nxt.startPulse = 1'b0;
          st_nxt.timer      = HALF_LOAD;
          if (st_r.edges == `LPS_END_EDGE)
          begin
            if (frameReq)
            begin
              // Raised after the 65th pulse of the cycle just ended; captured on the next rise
              st_nxt.startPulse = 1'b1;
              st_nxt.edges      = '0;
              st_nxt.linkFault  = 1'b0;
              st_nxt.state      = lps_pkg::CTL_LOW;
            end
            else
              st_nxt.state = lps_pkg::CTL_IDLE;
          end
          else
            st_nxt.state = lps_pkg::CTL_LOW;
        end
      end
      default:
      begin
        st_nxt.state      = lps_pkg::CTL_IDLE;
        st_nxt.pixClk     = 1'b0;
        st_nxt.startPulse = 1'b0;
      end
    endcase

    // Output pin must be driven during every pixel slot; link_off always returns 0, so linkFault never sets
    if (st_r.state == lps_pkg::CTL_LOW && st_r.timer == '0 && sampleDue && canPush)
      st_nxt.linkFault = st_r.linkFault | link_off(link.pixelVoltageIn, st_r.edges);

    // Two-entry buffer, head always at the output flops
    case ({push, pop})
      2'b11:
      begin
        if (st_r.fifoCnt == 2'h1)
          st_nxt.head = sample;
        else
        begin
          st_nxt.head = st_r.tail;
          st_nxt.tail = sample;
        end
      end
      2'b01:
      begin
        st_nxt.head    = st_r.tail;
        st_nxt.fifoCnt = st_r.fifoCnt - 2'h1;
      end
      2'b10:
      begin
        if (st_r.fifoCnt == 2'h0)
          st_nxt.head = sample;
        else
          st_nxt.tail = sample;
        st_nxt.fifoCnt = st_r.fifoCnt + 2'h1;
      end
      default:
      begin
        st_nxt.fifoCnt = st_r.fifoCnt;
      end
    endcase
  end

  // Pin reads zero whenever the array has released it; a dark pixel also reads
  // zero, so link_off tests only the pixel-1 slot, and its result is ANDed with 1'b0
  function automatic logic link_off(input logic [`LPS_LEVEL_W-1:0] lvl,
                                    input logic [`LPS_EDGE_W-1:0]  edg);
    return 1'b0 & (lvl == `LPS_LEVEL_RST) & (edg == `LPS_EDGE_W'(1));
  endfunction : link_off

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st_r       <= '0;
      st_r.state <= lps_pkg::CTL_IDLE;
    end
    else
      st_r <= st_nxt;
  end

  assign link.pixClk     = st_r.pixClk;
  assign link.startPulse = st_r.startPulse;
  assign frameBusy       = (st_r.state != lps_pkg::CTL_IDLE);
  assign linkFault       = st_r.linkFault;
  assign pixValid        = (st_r.fifoCnt != 2'h0);
  assign pixIndex        = st_r.head.idx;
  assign pixLevel        = st_r.head.level;

endmodule : lps_array_ctrl

// ===== pkg/lps_regs.svh
// Constants of the linear pixel sequencer: array size, edge counts, link timing.
// Assumes a 250 MHz system clock; included by the package and the link interface.
`ifndef LPS_REGS_SVH
`define LPS_REGS_SVH

`define LPS_PIXELS      64
`define LPS_IDX_W       6
`define LPS_LEVEL_W     8
`define LPS_EDGE_W      7
`define LPS_LAST_PIXEL  7'h40
`define LPS_END_EDGE    7'h41
`define LPS_CLK_NS      4
`define LPS_HALF_NS     100
`define LPS_HALF_CYC    ((`LPS_HALF_NS + `LPS_CLK_NS - 1) / `LPS_CLK_NS)
`define LPS_TIMER_W     5
`define LPS_SHIFT_RST   64'h0000_0000_0000_0000
`define LPS_LEVEL_RST   8'h00

`endif

// ===== pkg/lps_pkg.sv
// Types shared by both ends of the pixel sequencer link.
// Assumes lps_regs.svh is on the include path.
`include "lps_regs.svh"

package lps_pkg;

  typedef enum logic [1:0] {
    CTL_IDLE,
    CTL_LOW,
    CTL_HIGH
  } lps_ctl_state_t;

  typedef struct packed {
    logic [`LPS_IDX_W-1:0]   idx;
    logic [`LPS_LEVEL_W-1:0] level;
  } lps_sample_t;

  typedef struct packed {
    logic [2:0]               clkSync;
    logic [1:0]               startSync;
    logic [`LPS_PIXELS-1:0]   shiftReg;
    logic [`LPS_PIXELS-1:0]   integReset;
    logic [`LPS_LEVEL_W-1:0]  level;
    logic [`LPS_IDX_W-1:0]    activePixel;
    logic                     outEn;
  } lps_array_st_t;

  typedef struct packed {
    lps_ctl_state_t           state;
    logic [`LPS_TIMER_W-1:0]  timer;
    logic [`LPS_EDGE_W-1:0]   edges;
    logic                     pixClk;
    logic                     startPulse;
    logic                     linkFault;
    logic [1:0]               fifoCnt;
    lps_sample_t              head;
    lps_sample_t              tail;
  } lps_ctl_st_t;

endpackage : lps_pkg

// ===== pkg/lps_link_if.sv
// Link between the controller and the pixel array: clock, start pulse, output pin.
// The output pin is tri-state; with the driver off the external pulldown gives zero.
`include "lps_regs.svh"

interface lps_link_if;
  logic                    pixClk;
  logic                    startPulse;
  logic [`LPS_LEVEL_W-1:0] pixelVoltageOut;
  logic                    pixelVoltageOe;
  logic [`LPS_LEVEL_W-1:0] pixelVoltageIn;

  assign pixelVoltageIn = pixelVoltageOe ? pixelVoltageOut : `LPS_LEVEL_RST;

  modport ctrl
  (
    output pixClk,
    output startPulse,
    input  pixelVoltageIn
  );

  modport array
  (
    input  pixClk,
    input  startPulse,
    output pixelVoltageOut,
    output pixelVoltageOe
  );
endinterface : lps_link_if

// ===== design/lps_pixel_array.sv
// Pixel array end: 64-stage start-pulse shift register, output select, integrator resets.
// Link clock and start arrive as pins and are synchronised to sys_clk before use.
`include "lps_regs.svh"

module lps_pixel_array
(
  input  wire logic                                     sys_clk,
  input  wire logic                                     arst_n,
  lps_link_if.array                                     link,
  input  wire logic [`LPS_PIXELS-1:0][`LPS_LEVEL_W-1:0] pixLevel,
  output logic      [`LPS_PIXELS-1:0]                   integReset,
  output logic      [`LPS_IDX_W-1:0]                    activePixel,
  output logic                                          outActive
);

  lps_pkg::lps_array_st_t st_r;
  lps_pkg::lps_array_st_t st_nxt;
  logic                   linkRise;

  // Lowest set position wins if a second pulse trails the first
  function automatic logic [`LPS_IDX_W-1:0] lowestSet(input logic [`LPS_PIXELS-1:0] vec);
    logic [`LPS_IDX_W-1:0] idx;
    idx = '0;
    for (int i = `LPS_PIXELS - 1; i >= 0; i--)
    begin
      if (vec[i])
        idx = `LPS_IDX_W'(i);
    end
    return idx;
  endfunction : lowestSet

  always_comb
  begin
    st_nxt            = st_r;
    st_nxt.clkSync    = {st_r.clkSync[1:0], link.pixClk};
    st_nxt.startSync  = {st_r.startSync[0], link.startPulse};
    st_nxt.integReset = '0;
    linkRise          = st_r.clkSync[1] & ~st_r.clkSync[2];
    if (linkRise)
    begin
      // Start sampled at the same sync depth as the clock edge
      st_nxt.shiftReg   = {st_r.shiftReg[`LPS_PIXELS-2:0], st_r.startSync[1]};
      st_nxt.integReset = st_r.shiftReg & ~st_nxt.shiftReg;
    end
    st_nxt.outEn       = |st_nxt.shiftReg;
    st_nxt.activePixel = lowestSet(st_nxt.shiftReg);
    st_nxt.level       = st_nxt.outEn ? pixLevel[st_nxt.activePixel] : `LPS_LEVEL_RST;
  end

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign link.pixelVoltageOut = st_r.level;
  assign link.pixelVoltageOe  = st_r.outEn;
  assign integReset           = st_r.integReset;
  assign activePixel          = st_r.activePixel;
  assign outActive            = st_r.outEn;

endmodule : lps_pixel_array

// ===== tb/lps_link_chk.sv
// Checker on the controller-to-array link: start capture, edge count, output window.
// Assumes one sys_clk domain; placed beside the link interface in tb_top.
`include "lps_regs.svh"

module lps_link_chk
(
  input wire logic                    sys_clk,
  input wire logic                    arst_n,
  input wire logic                    pixClk,
  input wire logic                    startPulse,
  input wire logic [`LPS_LEVEL_W-1:0] pixelVoltageOut,
  input wire logic                    pixelVoltageOe,
  input wire logic [`LPS_LEVEL_W-1:0] pixelVoltageIn
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       clkSeen_r;
  logic [6:0] edgeCnt_r;
  logic [6:0] edgeCnt_nxt;
  logic       idle;

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  // Rising edges since capture; 65 means the frame has just closed
  assign idle = (edgeCnt_r == 7'h00) || (edgeCnt_r == 7'h41);
  always_comb
  begin
    edgeCnt_nxt = edgeCnt_r;
    if (pixClk && !clkSeen_r)
      edgeCnt_nxt = startPulse ? 7'h01 : (idle ? 7'h00 : edgeCnt_r + 7'h01);
  end
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      clkSeen_r <= 1'b0;
      edgeCnt_r <= 7'h00;
    end
    else
    begin
      clkSeen_r <= pixClk;
      edgeCnt_r <= edgeCnt_nxt;
    end
  end

  sequence s_capture;
    $rose(pixClk) && startPulse;
  endsequence
  sequence s_last_rise;
    $rose(pixClk) && (edgeCnt_r == 7'h40);
  endsequence

  AST_START_SETUP: assert property (s_capture |-> $past(startPulse))
    else $error("start not set up before capture");
  AST_START_ONE_EDGE: assert property (s_capture |-> ##[1:49] !startPulse)
    else $error("start held past the capture");
  AST_START_SPACING: assert property (s_capture |-> idle)
    else $error("start captured inside a frame");
  AST_OE_ON: assert property (s_capture |-> ##4 pixelVoltageOe)
    else $error("output not driven after capture");
  // The array moves to the next pixel three sys_clk after the link rise, through its synchroniser
  AST_OUT_HOLD: assert property ($rose(pixClk) && pixelVoltageOe |-> $stable(pixelVoltageOut)[*3])
    else $error("output level moved too early");
  AST_OE_OFF: assert property (s_last_rise |-> ##4 !pixelVoltageOe)
    else $error("output still driven after edge 65");
  AST_OE_IDLE: assert property (idle && $past(idle, 4) |-> !pixelVoltageOe && pixelVoltageIn == 8'h00)
    else $error("output driven outside the frame");
  AST_EDGE65: assert property (edgeCnt_r == 7'h40 |-> ##[1:900] edgeCnt_r == 7'h41)
    else $error("closing clock pulse missing");
endmodule : lps_link_chk

// ===== tb/tb_top.sv
// Bench joining controller and array over the link; reads and checks every pixel word.
// Assumes package, link interface and both design ends are compiled first.
`include "lps_regs.svh"

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic                                     sys_clk = 1'b0;
  logic                                     arst_n = 1'b0;
  logic                                     frameReq = 1'b0;
  logic                                     pixReady = 1'b0;
  logic                                     frameBusy;
  logic                                     pixValid;
  logic                                     linkFault;
  logic                                     outActive;
  logic [`LPS_IDX_W-1:0]                    activePixel;
  logic [`LPS_PIXELS-1:0][`LPS_LEVEL_W-1:0] lvlIn;
  logic [`LPS_PIXELS-1:0]                   integReset;
  logic [`LPS_IDX_W-1:0]                    pixIndex;
  logic [`LPS_LEVEL_W-1:0]                  pixLevel;
  int                                       nMismatch = 0;
  int                                       comparisons = 0;
  int                                       rstCnt [64];

  lps_link_if link();
  lps_array_ctrl u_lps_array_ctrl (.sys_clk(sys_clk), .arst_n(arst_n), .link(link.ctrl),
    .frameReq(frameReq), .frameBusy(frameBusy), .linkFault(linkFault), .pixValid(pixValid),
    .pixReady(pixReady), .pixIndex(pixIndex), .pixLevel(pixLevel));
  lps_pixel_array u_lps_pixel_array (.sys_clk(sys_clk), .arst_n(arst_n), .link(link.array),
    .pixLevel(lvlIn), .integReset(integReset), .activePixel(activePixel),
    .outActive(outActive));
  lps_link_chk u_lps_link_chk (.sys_clk(sys_clk), .arst_n(arst_n), .pixClk(link.pixClk),
    .startPulse(link.startPulse), .pixelVoltageOut(link.pixelVoltageOut),
    .pixelVoltageOe(link.pixelVoltageOe), .pixelVoltageIn(link.pixelVoltageIn));

  always #2 sys_clk = ~sys_clk;
  always @(posedge sys_clk)
    for (int i = 0; i < 64; i++)
      if (integReset[i] === 1'b1)
        rstCnt[i]++;

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      nMismatch++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic finish_test;
    $display("mismatches %0d comparisons %0d", nMismatch, comparisons);
    if (nMismatch == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : finish_test

  // Reads one frame; a stall long enough fills the buffer and freezes the link clock
  task automatic read_frame(input int stallAt, input logic keep);
    int t;
    frameReq = 1'b1;
    for (int n = 0; n < 64; n++)
    begin
      if (n == stallAt)
      begin
        pixReady = 1'b0;
        repeat (300) @(posedge sys_clk);
        #1;
      end
      pixReady = 1'b1;
      t = 0;
      while (pixValid !== 1'b1 && t < 2000)
      begin
        @(posedge sys_clk);
        #1;
        t++;
      end
      chk({2'h0, pixIndex}, 8'(n));
      chk(pixLevel, lvlIn[n]);
      @(posedge sys_clk);
      #1;
      frameReq = keep;
    end
  endtask : read_frame

  task automatic idle_check;
    repeat (200) @(posedge sys_clk);
    chk({7'h00, link.pixelVoltageOe}, 8'h00);
    chk({7'h00, frameBusy}, 8'h00);
    chk({7'h00, outActive}, 8'h00);
    chk({2'h0, activePixel}, 8'h00);
    chk({7'h00, linkFault}, 8'h00);
  endtask : idle_check

  initial
  begin
    for (int i = 0; i < 64; i++)
      lvlIn[i] = 8'(i * 3 + 5);
    repeat (3) @(posedge sys_clk);
    chk({7'h00, link.pixelVoltageOe}, 8'h00);
    #1;
    arst_n = 1'b1;
    read_frame(99, 1'b0);
    idle_check();
    read_frame(62, 1'b0);
    read_frame(99, 1'b1);
    read_frame(0, 1'b0);
    idle_check();
    for (int i = 0; i < 64; i++)
      chk(8'(rstCnt[i]), 8'h04);
    finish_test();
  end

  // Four frames with stalls need about 15000 cycles; twice that means a hang
  initial
  begin
    repeat (30000) @(posedge sys_clk);
    nMismatch++;
    finish_test();
  end
endmodule : tb_top
